// File: ssq_pkg.sv
// Shared constants, types and register map of the shunt and bus conversion sequencer.
package ssq_pkg;

	// Register indices on the plain register port.
	localparam logic [3:0] SSQ_REG_CONFIG   = 4'h0;
	localparam logic [3:0] SSQ_REG_SHUNT    = 4'h1;
	localparam logic [3:0] SSQ_REG_BUS      = 4'h2;
	localparam logic [3:0] SSQ_REG_POWER    = 4'h3;
	localparam logic [3:0] SSQ_REG_CURRENT  = 4'h4;
	localparam logic [3:0] SSQ_REG_CAL      = 4'h5;
	localparam logic [3:0] SSQ_REG_STATUS   = 4'h6;
	localparam logic [3:0] SSQ_REG_IRQ_STAT = 4'h7;
	localparam logic [3:0] SSQ_REG_IRQ_MASK = 4'h8;

	// Operating mode codes.
	localparam logic [2:0] SSQ_MODE_PDOWN     = 3'h0;
	localparam logic [2:0] SSQ_MODE_SHUNT_TRG = 3'h1;
	localparam logic [2:0] SSQ_MODE_BUS_TRG   = 3'h2;
	localparam logic [2:0] SSQ_MODE_BOTH_TRG  = 3'h3;
	localparam logic [2:0] SSQ_MODE_ADC_OFF   = 3'h4;
	localparam logic [2:0] SSQ_MODE_SHUNT_CNT = 3'h5;
	localparam logic [2:0] SSQ_MODE_BUS_CNT   = 3'h6;
	localparam logic [2:0] SSQ_MODE_BOTH_CNT  = 3'h7;

	// Mode code bit meanings: bit 0 shunt, bit 1 bus, bit 2 continuous.
	localparam int SSQ_MODE_SHUNT_BIT = 0;
	localparam int SSQ_MODE_BUS_BIT   = 1;
	localparam int SSQ_MODE_CONT_BIT  = 2;

	// Status and interrupt bit positions.
	localparam int SSQ_ST_READY_BIT = 0;
	localparam int SSQ_ST_BUSY_BIT  = 1;
	localparam int SSQ_IRQ_DONE_BIT = 0;
	localparam int SSQ_IRQ_WAKE_BIT = 1;
	localparam int SSQ_IRQ_W        = 2;

	// Timing: conversion time per sample and power-down recovery.
	localparam int SSQ_CLK_MHZ      = 200;
	localparam int SSQ_CONV_TIME_US = 532;
	localparam int SSQ_WAKE_TIME_US = 40;
	localparam int SSQ_CONV_CYCLES  = SSQ_CONV_TIME_US * SSQ_CLK_MHZ;
	localparam int SSQ_WAKE_CYCLES  = SSQ_WAKE_TIME_US * SSQ_CLK_MHZ;
	localparam int SSQ_TIMER_W      = 20;

	// Arithmetic scaling of the background current and power calculation.
	localparam int SSQ_CUR_SHIFT = 12;
	localparam logic [31:0] SSQ_PWR_DIV = 32'h0000_1388;

	// Reset values.
	localparam logic [15:0] SSQ_CONFIG_RST = 16'h0007;

	// Configuration register layout.
	typedef struct packed {
		logic [6:0] rsvd;
		logic [2:0] bus_averaging_field;
		logic [2:0] shunt_averaging_field;
		logic [2:0] mode;
	} ssq_cfg_t;

	// Result registers that are committed together.
	typedef struct packed {
		logic [15:0] shunt;
		logic [15:0] bus;
		logic [15:0] current;
		logic [15:0] power;
	} ssq_res_t;

	// Register port request.
	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} ssq_req_t;

	// Sequencer states.
	typedef enum logic [2:0] {
		SSQ_IDLE,
		SSQ_WAKE,
		SSQ_SHUNT,
		SSQ_BUS,
		SSQ_CALC
	} ssq_state_t;

endpackage

// File: ssq_sequencer.sv
// Conversion sequencer with result, status, interrupt and register logic of the current and power monitor.
//
// The implementer's own choices: the address map and the plain strobed port.

// Summary of operation
// - Continuous shunt-and-bus mode repeatedly converts shunt, averaging 2 to the power shunt_averaging_field samples.
// - After the shunt average, each cycle converts bus with 2 to the power bus_averaging_field samples.
// - Modes also convert only shunt or only bus, continuous or single triggered.
// - Current and power are computed in background, adding no conversion time.
// - Leaving power-down waits a recovery interval; host waits it before expecting results.
// - ADC-off mode halts all conversion until a different mode is written.
// - Every write of a triggered mode starts one single-shot, even if unchanged.
// - Results readable anytime and hold last completed conversion until replaced.
// - conversion_ready_flag sets only after conversions, averaging and multiplication finish.
// - Configuration writes clear the flag, except writes selecting power-down or ADC-off.
// - Reading the status register clears the flag.
// - A single-shot started by the convert input clears the flag.
// - Current and power stay zero until calibration is written, then follow measurements.
module ssq_sequencer
	import ssq_pkg::*;
#(
	parameter int CONV_CYCLES = ssq_pkg::SSQ_CONV_CYCLES,
	parameter int WAKE_CYCLES = ssq_pkg::SSQ_WAKE_CYCLES
)
(
	// Clock and reset.
	input  wire logic               clk_sys,
	input  wire logic               rst,
	// Register port.
	input  wire ssq_pkg::ssq_req_t  req,
	output logic [15:0]             rd_data,
	// Convert pin and sample inputs from the converter front end.
	input  wire logic               convert_pin,
	input  wire logic [15:0]        shunt_sample,
	input  wire logic [15:0]        bus_sample,
	// Status outputs.
	output logic                    conversion_ready_flag,
	output logic                    irq
);
	import ssq_pkg::*;

	localparam logic [SSQ_TIMER_W-1:0] CONV_LAST = SSQ_TIMER_W'(CONV_CYCLES - 1);
	localparam logic [SSQ_TIMER_W-1:0] WAKE_LAST = SSQ_TIMER_W'(WAKE_CYCLES - 1);

	ssq_state_t              st_q,     st_d;
	ssq_cfg_t                cfg_q,    cfg_d;
	ssq_res_t                res_q,    res_d;
	logic [15:0]             cal_q,    cal_d;
	logic                    cal_ok_q, cal_ok_d;
	logic                    ready_q,  ready_d;
	logic                    pend_q,   pend_d;
	logic [SSQ_TIMER_W-1:0]  tmr_q,    tmr_d;
	logic [7:0]              cnt_q,    cnt_d;
	logic [22:0]             acc_q,    acc_d;
	logic [15:0]             sh_tmp_q, sh_tmp_d;
	logic [15:0]             bu_tmp_q, bu_tmp_d;
	logic [SSQ_IRQ_W-1:0]    ist_q,    ist_d;
	logic [SSQ_IRQ_W-1:0]    imsk_q,   imsk_d;
	logic [15:0]             rd_q,     rd_d;
	logic                    irq_q,    irq_d;
	logic                    pin_s1_q, pin_s2_q, pin_s3_q;

	logic                    cfg_wr, stat_rd, pin_rise, pin_trig, quiet_mode;
	logic [2:0]              avg_code;
	logic [7:0]              avg_last;
	logic [22:0]             acc_sum;
	logic [31:0]             cur_prod, pwr_prod;
	logic [15:0]             cur_val, pwr_val;
	ssq_cfg_t                wcfg;

	// Convert pin synchroniser; only the second stage and the edge register are read by logic.
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
			pin_s3_q <= 1'b0;
		end
		else
		begin
			pin_s1_q <= convert_pin;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	// Decodes and background arithmetic, evaluated every cycle; the products are used in the calculation cycle only.
	always_comb
	begin
		wcfg       = ssq_cfg_t'(req.wdata);
		cfg_wr     = req.wr && (req.addr == SSQ_REG_CONFIG);
		stat_rd    = req.rd && (req.addr == SSQ_REG_STATUS);
		pin_rise   = pin_s2_q && !pin_s3_q;
		pin_trig   = pin_rise && !cfg_q.mode[SSQ_MODE_CONT_BIT] && (cfg_q.mode != SSQ_MODE_PDOWN);
		quiet_mode = (wcfg.mode == SSQ_MODE_PDOWN) || (wcfg.mode == SSQ_MODE_ADC_OFF);
		avg_code   = (st_q == SSQ_BUS) ? cfg_q.bus_averaging_field : cfg_q.shunt_averaging_field;
		avg_last   = 8'((9'h001 << avg_code) - 9'h001);
		acc_sum    = acc_q + {7'h00, (st_q == SSQ_BUS) ? bus_sample : shunt_sample};
		cur_prod   = sh_tmp_q * cal_q;
		cur_val    = cur_prod[SSQ_CUR_SHIFT +: 16];
		pwr_prod   = cur_val * bu_tmp_q;
		pwr_val    = 16'(pwr_prod / SSQ_PWR_DIV);
	end

	// Next-state logic of the sequencer, result registers, flags and register port.
	always_comb
	begin
		st_d     = st_q;
		cfg_d    = cfg_q;
		res_d    = res_q;
		cal_d    = cal_q;
		cal_ok_d = cal_ok_q;
		ready_d  = ready_q;
		pend_d   = pend_q;
		tmr_d    = tmr_q;
		cnt_d    = cnt_q;
		acc_d    = acc_q;
		sh_tmp_d = sh_tmp_q;
		bu_tmp_d = bu_tmp_q;
		ist_d    = ist_q;
		imsk_d   = imsk_q;
		rd_d     = 16'h0000;

		// Sequencer proper; sampling waits a full conversion time per sample.
		case (st_q)
			SSQ_IDLE:
			begin
				tmr_d = '0;
				cnt_d = '0;
				acc_d = '0;
				if (cfg_q.mode[SSQ_MODE_CONT_BIT] || pend_q)
				begin
					if (cfg_q.mode == SSQ_MODE_ADC_OFF)
						st_d = SSQ_IDLE;
					else if (cfg_q.mode[SSQ_MODE_SHUNT_BIT])
						st_d = SSQ_SHUNT;
					else
						st_d = SSQ_BUS;
					pend_d = 1'b0;
				end
			end
			SSQ_WAKE:
			begin
				tmr_d = tmr_q + 1'b1;
				if (tmr_q == WAKE_LAST)
				begin
					st_d = SSQ_IDLE;
					ist_d[SSQ_IRQ_WAKE_BIT] = 1'b1;
				end
			end
			SSQ_SHUNT, SSQ_BUS:
			begin
				tmr_d = tmr_q + 1'b1;
				if (tmr_q == CONV_LAST)
				begin
					tmr_d = '0;
					acc_d = acc_sum;
					cnt_d = cnt_q + 1'b1;
					if (cnt_q == avg_last)
					begin
						acc_d = '0;
						cnt_d = '0;
						if (st_q == SSQ_SHUNT)
						begin
							sh_tmp_d = 16'(acc_sum >> avg_code);
							st_d = cfg_q.mode[SSQ_MODE_BUS_BIT] ? SSQ_BUS : SSQ_CALC;
						end
						else
						begin
							bu_tmp_d = 16'(acc_sum >> avg_code);
							st_d = SSQ_CALC;
						end
					end
				end
			end
			SSQ_CALC:
			begin
				// All results change in this one cycle, so a read never sees a mixed set.
				res_d.shunt   = sh_tmp_q;
				res_d.bus     = bu_tmp_q;
				res_d.current = cal_ok_q ? cur_val : 16'h0000;
				res_d.power   = cal_ok_q ? pwr_val : 16'h0000;
				st_d          = SSQ_IDLE;
				ist_d[SSQ_IRQ_DONE_BIT] = 1'b1;
			end
			default:
				st_d = SSQ_IDLE;
		endcase

		// Convert pin starts a single shot in triggered modes.
		if (pin_trig)
		begin
			pend_d  = 1'b1;
			ready_d = 1'b0;
		end

		// Register reads; data stands in the following cycle.
		if (req.rd)
		begin
			case (req.addr)
				SSQ_REG_CONFIG:   rd_d = cfg_q;
				SSQ_REG_SHUNT:    rd_d = res_q.shunt;
				SSQ_REG_BUS:      rd_d = res_q.bus;
				SSQ_REG_POWER:    rd_d = res_q.power;
				SSQ_REG_CURRENT:  rd_d = res_q.current;
				SSQ_REG_CAL:      rd_d = cal_q;
				SSQ_REG_STATUS:   rd_d = {14'h0000, st_q != SSQ_IDLE, ready_q};
				SSQ_REG_IRQ_STAT: rd_d = {14'h0000, ist_q};
				SSQ_REG_IRQ_MASK: rd_d = {14'h0000, imsk_q};
				default:          rd_d = 16'h0000;
			endcase
		end
		if (stat_rd)
			ready_d = 1'b0;

		// Register writes; a configuration write aborts any conversion in progress.
		if (req.wr)
		begin
			case (req.addr)
				SSQ_REG_CONFIG:
				begin
					cfg_d      = wcfg;
					cfg_d.rsvd = '0;
					tmr_d      = '0;
					pend_d     = !wcfg.mode[SSQ_MODE_CONT_BIT] && (wcfg.mode != SSQ_MODE_PDOWN);
					if (wcfg.mode == SSQ_MODE_PDOWN)
						st_d = SSQ_IDLE;
					else if (cfg_q.mode == SSQ_MODE_PDOWN || st_q == SSQ_WAKE)
						st_d = SSQ_WAKE;
					else
						st_d = SSQ_IDLE;
					if (!quiet_mode)
						ready_d = 1'b0;
				end
				SSQ_REG_CAL:
				begin
					cal_d    = req.wdata;
					cal_ok_d = 1'b1;
				end
				SSQ_REG_IRQ_STAT: ist_d  = ist_d & ~req.wdata[SSQ_IRQ_W-1:0];
				SSQ_REG_IRQ_MASK: imsk_d = req.wdata[SSQ_IRQ_W-1:0];
				default:          cal_d  = cal_q;
			endcase
		end

		// Events win over clears issued in the same cycle.
		if (st_q == SSQ_CALC)
			ready_d = 1'b1;
		if (st_q == SSQ_CALC)
			ist_d[SSQ_IRQ_DONE_BIT] = 1'b1;
		if (st_q == SSQ_WAKE && tmr_q == WAKE_LAST)
			ist_d[SSQ_IRQ_WAKE_BIT] = 1'b1;
		irq_d = |(ist_d & imsk_d);
	end

	// State registers of the whole block except the convert pin synchroniser.
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			st_q     <= SSQ_IDLE;
			cfg_q    <= ssq_cfg_t'(SSQ_CONFIG_RST);
			res_q    <= '0;
			cal_q    <= '0;
			cal_ok_q <= 1'b0;
			ready_q  <= 1'b0;
			pend_q   <= 1'b0;
			tmr_q    <= '0;
			cnt_q    <= '0;
			acc_q    <= '0;
			sh_tmp_q <= '0;
			bu_tmp_q <= '0;
			ist_q    <= '0;
			imsk_q   <= '0;
			rd_q     <= '0;
			irq_q    <= 1'b0;
		end
		else
		begin
			st_q     <= st_d;
			cfg_q    <= cfg_d;
			res_q    <= res_d;
			cal_q    <= cal_d;
			cal_ok_q <= cal_ok_d;
			ready_q  <= ready_d;
			pend_q   <= pend_d;
			tmr_q    <= tmr_d;
			cnt_q    <= cnt_d;
			acc_q    <= acc_d;
			sh_tmp_q <= sh_tmp_d;
			bu_tmp_q <= bu_tmp_d;
			ist_q    <= ist_d;
			imsk_q   <= imsk_d;
			rd_q     <= rd_d;
			irq_q    <= irq_d;
		end
	end

	assign rd_data               = rd_q;
	assign conversion_ready_flag = ready_q;
	assign irq                   = irq_q;

	// Checks on the sequencer, the ready flag and the results.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence seq_trig_write;
		cfg_wr && !quiet_mode && !wcfg.mode[SSQ_MODE_CONT_BIT] && cfg_q.mode != SSQ_MODE_PDOWN && st_q != SSQ_WAKE;
	endsequence

	sequence seq_idle_quiet;
		!req.wr && !pin_trig;
	endsequence

	AST_FLAG_SET: assert property (st_q == SSQ_CALC |=> ready_q && st_q == SSQ_IDLE)
		else $error("ready flag not set after calculation");
	AST_FLAG_ONLY_CALC: assert property (!ready_q ##1 ready_q |-> $past(st_q) == SSQ_CALC)
		else $error("ready flag set outside calculation");
	AST_READ_CLR: assert property (stat_rd && st_q != SSQ_CALC |=> !ready_q)
		else $error("status read did not clear ready flag");
	AST_CFG_CLR: assert property (cfg_wr && !quiet_mode && st_q != SSQ_CALC |=> !ready_q)
		else $error("configuration write did not clear ready flag");
	AST_CFG_KEEP: assert property (cfg_wr && quiet_mode && !pin_trig && st_q != SSQ_CALC |=> $stable(ready_q))
		else $error("quiet mode write changed ready flag");
	AST_PIN_CLR: assert property (pin_trig && !req.wr && st_q != SSQ_CALC |=> !ready_q ##1 st_q != SSQ_IDLE)
		else $error("convert pin did not start a cleared single shot");
	AST_TRIG_START: assert property (seq_trig_write ##1 seq_idle_quiet |=> st_q == SSQ_SHUNT || st_q == SSQ_BUS)
		else $error("triggered mode write did not start a conversion");
	AST_OFF_HALT: assert property ((cfg_q.mode == SSQ_MODE_ADC_OFF && st_q == SSQ_IDLE) and seq_idle_quiet |=> st_q == SSQ_IDLE)
		else $error("conversion started in ADC-off mode");
	AST_CAL_ZERO: assert property (!cal_ok_q |-> res_q.current == 16'h0000 && res_q.power == 16'h0000)
		else $error("current or power nonzero before calibration");
	AST_RES_HOLD: assert property (st_q != SSQ_CALC |=> $stable(res_q))
		else $error("results changed outside calculation");
	AST_SHUNT_TO_BUS: assert property ($past(st_q) == SSQ_SHUNT && st_q == SSQ_CALC |-> !$past(cfg_q.mode[SSQ_MODE_BUS_BIT]))
		else $error("bus conversion skipped");
	AST_WAKE_LEN: assert property (st_q == SSQ_WAKE && tmr_q == '0 ##1 !req.wr [*8] |-> st_q == SSQ_WAKE)
		else $error("power-down recovery ended early");

endmodule

// File: ssq_front.sv
// Behavioural converter front end that feeds samples to the sequencer.
module ssq_front
(
	// Clock.
	input  wire logic        clk_sys,
	// Levels the bench wants the front end to measure.
	input  wire logic [15:0] shunt_set,
	input  wire logic [15:0] bus_set,
	// Samples towards the sequencer.
	output logic      [15:0] shunt_sample,
	output logic      [15:0] bus_sample
);
	timeunit 1ns;
	timeprecision 1ps;

	// A real converter lags its input, so the model presents each level one clock late.
	always_ff @(posedge clk_sys)
	begin
		shunt_sample <= shunt_set;
		bus_sample   <= bus_set;
	end
endmodule

// File: ssq_sequencer_tb.sv
// Self-checking testbench of the shunt and bus conversion sequencer.
module ssq_sequencer_tb import ssq_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	// Short counts keep the run brief; every timing expectation derives from them.
	localparam int CONV = 8;
	localparam int WAKE = 16;

	typedef struct packed {
		logic [15:0] cfg;
		logic [15:0] sh;
		logic [15:0] bu;
	} ssq_row_t;

	logic        clk_sys;
	logic        rst;
	logic        convert_pin;
	logic        conversion_ready_flag;
	logic        irq;
	ssq_req_t    req;
	logic [15:0] rd_data;
	logic [15:0] shunt_set;
	logic [15:0] bus_set;
	logic [15:0] shunt_sample;
	logic [15:0] bus_sample;
	logic [15:0] d;
	logic [15:0] exp_sh;
	logic [15:0] exp_bu;
	logic [15:0] cur;
	logic [31:0] prod;
	int          n_fail;
	int          compares;
	int          n;
	int          lo;
	// Free-running cycle count; t_ref marks the start of the interval a flag is timed against.
	int          cyc = 0;
	int          t_ref;
	// Mode, averaging and sample levels; equal codes back to back retrigger.
	ssq_row_t    rows [7] = '{'{16'h0001, 16'h0100, 16'h0200}, '{16'h0001, 16'h0120, 16'h0200},
		'{16'h0082, 16'h0120, 16'h0300}, '{16'h004B, 16'h0111, 16'h0222}, '{16'h000D, 16'h0155, 16'h0222},
		'{16'h0046, 16'h0155, 16'h0333}, '{16'h0017, 16'h0177, 16'h0377}};

	ssq_sequencer #(.CONV_CYCLES(CONV), .WAKE_CYCLES(WAKE)) u_dut (.clk_sys(clk_sys), .rst(rst), .req(req),
		.rd_data(rd_data), .convert_pin(convert_pin), .shunt_sample(shunt_sample), .bus_sample(bus_sample),
		.conversion_ready_flag(conversion_ready_flag), .irq(irq));

	ssq_front u_front (.clk_sys(clk_sys), .shunt_set(shunt_set), .bus_set(bus_set),
		.shunt_sample(shunt_sample), .bus_sample(bus_sample));

	// Free-running system clock.
	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Cycle counter; continuous rows average at least two samples so a cycle outlasts the reads between flags.
	always @(posedge clk_sys)
		cyc <= cyc + 1;

	task automatic print_verdict;
		if (n_fail == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string w);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: %s got %h want %h", $time, w, got, exp);
		end
	endtask

	// A gap cycle after each strobe keeps every signal to one assignment per step.
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		t_ref = cyc;
		req.wr <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		req.rd <= 1'b0;
		@(negedge clk_sys);
		v = rd_data;
		@(posedge clk_sys);
	endtask

	task automatic lvl(input bit sel_irq, input logic v, input string w);
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		chk({15'h0000, sel_irq ? irq : conversion_ready_flag}, {15'h0000, v}, w);
		@(posedge clk_sys);
	endtask

	// Bounded wait for the flag; a flag earlier than the sampling time allows is wrong.
	task automatic wait_flag(input int min);
		n = 0;
		do
		begin
			@(negedge clk_sys);
			n++;
		end
		while (conversion_ready_flag !== 1'b1 && n < 2000);
		chk({15'h0000, n < 2000 && cyc - t_ref >= min}, 16'h0001, "conversion time");
		t_ref = cyc;
		@(posedge clk_sys);
	endtask

	task automatic chk_res;
		prod = exp_sh * 16'h2000;
		cur = prod[27:12];
		rd(SSQ_REG_SHUNT, d);
		chk(d, exp_sh, "shunt result");
		rd(SSQ_REG_BUS, d);
		chk(d, exp_bu, "bus result");
		rd(SSQ_REG_CURRENT, d);
		chk(d, cur, "current result");
		rd(SSQ_REG_POWER, d);
		chk(d, 16'((32'(cur) * 32'(exp_bu)) / 32'd5000), "power result");
	endtask

	// Hang guard, sized well above the expected run length.
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		print_verdict;
	end

	// Main sequence: reset, table of modes, then the awkward cases.
	initial
	begin
		rst = 1'b1;
		convert_pin = 1'b0;
		req = '0;
		shunt_set = 16'h0040;
		bus_set = 16'h1000;
		n_fail = 0;
		compares = 0;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		t_ref = cyc;
		lvl(0, 0, "flag after reset");
		rd(SSQ_REG_CONFIG, d);
		chk(d, 16'h0007, "config reset");
		wait_flag(2 * CONV + 2);
		rd(SSQ_REG_CURRENT, d);
		chk(d, 16'h0000, "current before cal");
		rd(SSQ_REG_POWER, d);
		chk(d, 16'h0000, "power before cal");
		wr(SSQ_REG_CAL, 16'h2000);
		rd(4'h9, d);
		chk(d, 16'h0000, "unmapped read");
		exp_sh = 16'h0040;
		exp_bu = 16'h1000;
		foreach (rows[i])
		begin
			shunt_set <= rows[i].sh;
			bus_set <= rows[i].bu;
			wr(SSQ_REG_CONFIG, rows[i].cfg);
			lvl(0, 0, "flag after config write");
			lo = ((rows[i].cfg[0] ? 1 << rows[i].cfg[5:3] : 0) + (rows[i].cfg[1] ? 1 << rows[i].cfg[8:6] : 0)) * CONV;
			wait_flag(lo + 2);
			if (rows[i].cfg[0])
				exp_sh = rows[i].sh;
			if (rows[i].cfg[1])
				exp_bu = rows[i].bu;
			chk_res;
			rd(SSQ_REG_STATUS, d);
			chk({15'h0000, d[0]}, 16'h0001, "status ready");
			lvl(0, 0, "flag after status read");
			if (rows[i].cfg[2])
				wait_flag(lo + 2);
		end
		// Converter off: flag kept, results frozen although the shunt input moves.
		wr(SSQ_REG_CONFIG, 16'h0004);
		lvl(0, 1, "flag after adc off write");
		shunt_set <= 16'h0999;
		repeat (40) @(posedge clk_sys);
		chk_res;
		rd(SSQ_REG_STATUS, d);
		chk(d, 16'h0001, "status while off");
		// Power-down, then a triggered run that must first sit out the recovery time.
		wr(SSQ_REG_IRQ_STAT, 16'h0003);
		wr(SSQ_REG_IRQ_MASK, 16'h0001);
		wr(SSQ_REG_CONFIG, 16'h0000);
		wr(SSQ_REG_CONFIG, 16'h0003);
		wait_flag(WAKE + 2 * CONV + 2);
		lvl(1, 1, "irq on done");
		rd(SSQ_REG_IRQ_STAT, d);
		chk(d, 16'h0003, "irq status");
		wr(SSQ_REG_IRQ_STAT, 16'h0001);
		lvl(1, 0, "irq after clear");
		wr(SSQ_REG_IRQ_MASK, 16'h0002);
		lvl(1, 1, "irq on wake");
		wr(SSQ_REG_IRQ_MASK, 16'h0000);
		lvl(1, 0, "irq masked");
		// Pin trigger after a four-sample shunt single shot has finished; 80 ns high.
		wr(SSQ_REG_CONFIG, 16'h0011);
		wait_flag(4 * CONV + 2);
		convert_pin <= 1'b1;
		t_ref = cyc;
		repeat (16) @(posedge clk_sys);
		convert_pin <= 1'b0;
		lvl(0, 0, "flag after pin trigger");
		wait_flag(4 * CONV + 2);
		print_verdict;
	end
endmodule
